/* File: common/ptob_defs.vh */
// Purpose: Shared constants for the transmit overhead byte register bank.
// Assumes: 8-bit register address, 16-bit register data.
// Notes:   Included by every file of the bank.
//
// Operation
// - F1 value held in bits 15:8.
// - Register F1 used only for select 10.
// - Software REI into G1 bits 1-4 when defeated.
// - Defeat bit one picks software REI.
// - Alarm bit 3 always into G1 bit 5.
// - Link status bits 2:0 into G1 6-8.
// - M2 value held in upper byte.
// - M1 value held in lower byte.
// - Register M bytes per select; 11 both.
// - Growth register one upper byte is Z2.
// - Growth register one lower byte is Z1.
// - Z4 from upper byte, ignored in E3.
// - Z3 from lower byte in every mode.
// - Z6 from upper byte, unused in E3.
// - Z5 from lower byte, unused in E3.
`ifndef PTOB_DEFS_VH
`define PTOB_DEFS_VH

// Register addresses.
`define PTOB_ADR_F1G1   8'h54
`define PTOB_ADR_M12    8'h56
`define PTOB_ADR_Z12    8'h58
`define PTOB_ADR_Z34    8'h5A
`define PTOB_ADR_Z56    8'h5C
`define PTOB_ADR_CTRL   8'h5E

// Reset and unmapped read values.
`define PTOB_RST16      16'h0000
`define PTOB_RST8       8'h00
`define PTOB_RST6       6'h00
`define PTOB_RST1       1'h0
`define PTOB_RSVD2      2'h0
`define PTOB_UNMAPPED   16'h0000

// Field positions: byte halves of each data register, and the G1 fields.
`define PTOB_HI         15:8
`define PTOB_LO         7:0
`define PTOB_REI        7:4
`define PTOB_RAI        3
`define PTOB_LSS        2:0

// Field positions of the control register.
`define PTOB_C_DEFEAT   0
`define PTOB_C_F1SEL    2:1
`define PTOB_C_MSEL     4:3
`define PTOB_C_E3       5
`define PTOB_C_BITS     5:0

// F1 source codes.
`define PTOB_F1_TRACE   2'h0
`define PTOB_F1_HDLC    2'h1
`define PTOB_F1_REG     2'h2

// M byte source codes.
`define PTOB_M_HDLC     2'h0
`define PTOB_M_M1REG    2'h1
`define PTOB_M_M2REG    2'h2
`define PTOB_M_BOTH     2'h3

// Write-select vector positions.
`define PTOB_S_F1G1     0
`define PTOB_S_M12      1
`define PTOB_S_Z12      2
`define PTOB_S_Z34      3
`define PTOB_S_Z56      4
`define PTOB_S_CTRL     5

`endif

/* File: design/ptob_bus_slave.v */
// Purpose: Address decode and registered read path of the bank.
// Assumes: Strobes are one cycle and never high together.
// Notes:   Read data stand only in the cycle after the read strobe.
`timescale 1ns/10ps
`include "ptob_defs.vh"

module ptob_bus_slave (
  // Clock and reset.
  input  wire        i_sys_clk,
  input  wire        i_rst,
  // Register port.
  input  wire [7:0]  i_addr,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  output reg  [15:0] o_rd_data,
  // Register contents for read back.
  input  wire [15:0] i_f1g1,
  input  wire [15:0] i_m12,
  input  wire [15:0] i_z12,
  input  wire [15:0] i_z34,
  input  wire [15:0] i_z56,
  input  wire [15:0] i_ctrl,
  // One-hot write selects.
  output wire [5:0]  o_wr_sel
);

  // True when the address matches the given register.
  function adr_hit;
    input [7:0] adr;
    input [7:0] reg_adr;
    begin
      adr_hit = (adr == reg_adr);
    end
  endfunction

  // Write selects qualify the decode with the strobe.
  assign o_wr_sel[`PTOB_S_F1G1] = i_wr_en & adr_hit(i_addr, `PTOB_ADR_F1G1);
  assign o_wr_sel[`PTOB_S_M12]  = i_wr_en & adr_hit(i_addr, `PTOB_ADR_M12);
  assign o_wr_sel[`PTOB_S_Z12]  = i_wr_en & adr_hit(i_addr, `PTOB_ADR_Z12);
  assign o_wr_sel[`PTOB_S_Z34]  = i_wr_en & adr_hit(i_addr, `PTOB_ADR_Z34);
  assign o_wr_sel[`PTOB_S_Z56]  = i_wr_en & adr_hit(i_addr, `PTOB_ADR_Z56);
  assign o_wr_sel[`PTOB_S_CTRL] = i_wr_en & adr_hit(i_addr, `PTOB_ADR_CTRL);

  // Read data for one cycle; reading changes nothing else.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= `PTOB_RST16;
    end else if (i_rd_en) begin
      case (i_addr)
        `PTOB_ADR_F1G1: o_rd_data <= i_f1g1;
        `PTOB_ADR_M12:  o_rd_data <= i_m12;
        `PTOB_ADR_Z12:  o_rd_data <= i_z12;
        `PTOB_ADR_Z34:  o_rd_data <= i_z34;
        `PTOB_ADR_Z56:  o_rd_data <= i_z56;
        `PTOB_ADR_CTRL: o_rd_data <= i_ctrl;
        default:        o_rd_data <= `PTOB_UNMAPPED;
      endcase
    end else begin
      o_rd_data <= `PTOB_RST16;
    end
  end

endmodule // ptob_bus_slave

/* File: design/ptob_oh_mux.v */
// Purpose: Selects the source of each transmitted overhead byte.
// Assumes: All inputs are stable register or source values.
// Notes:   Purely combinational; the caller samples the result.
`timescale 1ns/10ps
`include "ptob_defs.vh"

module ptob_oh_mux (
  // Register contents.
  input  wire [15:0] i_f1g1,
  input  wire [15:0] i_m12,
  input  wire [15:0] i_z34,
  input  wire [15:0] i_z56,
  input  wire [5:0]  i_ctrl,
  // Alternative byte sources.
  input  wire [3:0]  i_auto_rei,
  input  wire [7:0]  i_trace_f1,
  input  wire [7:0]  i_hdlc_f1,
  input  wire [7:0]  i_hdlc_m1,
  input  wire [7:0]  i_hdlc_m2,
  // Selected bytes.
  output reg  [7:0]  o_f1,
  output wire [7:0]  o_g1,
  output wire [7:0]  o_m1,
  output wire [7:0]  o_m2,
  output wire [7:0]  o_z4,
  output wire [7:0]  o_z5,
  output wire [7:0]  o_z6
);

  // Picks the register byte when enabled, else the other source.
  function [7:0] pick8;
    input       use_reg;
    input [7:0] reg_val;
    input [7:0] alt_val;
    begin
      pick8 = use_reg ? reg_val : alt_val;
    end
  endfunction

  wire [1:0] f1_source_select     = i_ctrl[`PTOB_C_F1SEL]; // F1 source code.
  wire [1:0] m_byte_source_select = i_ctrl[`PTOB_C_MSEL];  // M source code.
  wire       auto_remote_err_defeat = i_ctrl[`PTOB_C_DEFEAT];
  wire       e3_mode              = i_ctrl[`PTOB_C_E3];    // E3 framing.

  // F1 source; the reserved code sends zero.
  always @* begin
    case (f1_source_select)
      `PTOB_F1_TRACE: o_f1 = i_trace_f1;
      `PTOB_F1_HDLC:  o_f1 = i_hdlc_f1;
      `PTOB_F1_REG:   o_f1 = i_f1g1[`PTOB_HI];
      default:        o_f1 = `PTOB_RST8;
    endcase
  end

  // G1 bit 1 is the most significant bit of the byte.
  assign o_g1 = {auto_remote_err_defeat ? i_f1g1[`PTOB_REI] : i_auto_rei,
                 i_f1g1[`PTOB_RAI],
                 i_f1g1[`PTOB_LSS]};

  // M bytes from register only where the code selects it.
  assign o_m1 = pick8(m_byte_source_select[0], i_m12[`PTOB_LO], i_hdlc_m1);
  assign o_m2 = pick8(m_byte_source_select[1], i_m12[`PTOB_HI], i_hdlc_m2);

  // Z4, Z5 and Z6 carry nothing in E3 framing.
  assign o_z4 = pick8(~e3_mode, i_z34[`PTOB_HI], `PTOB_RST8);
  assign o_z5 = pick8(~e3_mode, i_z56[`PTOB_LO], `PTOB_RST8);
  assign o_z6 = pick8(~e3_mode, i_z56[`PTOB_HI], `PTOB_RST8);

endmodule // ptob_oh_mux

/* File: design/ptob_regs.v */
// Purpose: Transmit overhead byte register bank for one port.
// Assumes: Inputs are synchronous to i_sys_clk; one clock domain.
// Notes:   Overhead outputs change only on the insertion pulse.
`timescale 1ns/10ps
`include "ptob_defs.vh"

module ptob_regs (
  // Clock and reset.
  input  wire        i_sys_clk,
  input  wire        i_rst,

  // Register port.
  input  wire [7:0]  i_addr,
  input  wire [15:0] i_wr_data,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  output wire [15:0] o_rd_data,

  // Frame generator timing.
  input  wire        i_oh_sample,

  // Alternative byte sources.
  input  wire [3:0]  i_auto_rei,
  input  wire [7:0]  i_trace_f1,
  input  wire [7:0]  i_hdlc_f1,
  input  wire [7:0]  i_hdlc_m1,
  input  wire [7:0]  i_hdlc_m2,

  // Overhead bytes to the frame generator.
  output reg         o_oh_valid,
  output reg  [7:0]  o_f1_byte,
  output reg  [7:0]  o_g1_byte,
  output reg  [7:0]  o_m1_byte,
  output reg  [7:0]  o_m2_byte,
  output reg  [7:0]  o_z1_byte,
  output reg  [7:0]  o_z2_byte,
  output reg  [7:0]  o_z3_byte,
  output reg  [7:0]  o_z4_byte,
  output reg  [7:0]  o_z5_byte,
  output reg  [7:0]  o_z6_byte
);

  //////////////////////////////////////////////////////////////////////
  // Register storage.
  //////////////////////////////////////////////////////////////////////

  // F1 byte above the G1 fields.
  reg  [15:0] f1g1_ff;
  // M2 byte above the M1 byte.
  reg  [15:0] m12_ff;
  // Z2 byte above the Z1 byte.
  reg  [15:0] z12_ff;
  // Z4 byte above the Z3 byte.
  reg  [15:0] z34_ff;
  // Z6 byte above the Z5 byte.
  reg  [15:0] z56_ff;
  // Source selects, REI defeat and E3 mode.
  reg  [5:0]  ctrl_ff;

  // Next values of the storage.
  reg  [15:0] nxt_f1g1;
  reg  [15:0] nxt_m12;
  reg  [15:0] nxt_z12;
  reg  [15:0] nxt_z34;
  reg  [15:0] nxt_z56;
  reg  [5:0]  nxt_ctrl;

  // One-hot write selects from the decoder.
  wire [5:0]  wr_sel;

  // Control register as read: last sent G1 above the control bits.
  wire [15:0] ctrl_rd;

  // Named views of the software fields.
  wire [7:0]  sw_f1_value          = f1g1_ff[`PTOB_HI];
  wire [3:0]  sw_remote_err_value  = f1g1_ff[`PTOB_REI];
  wire        sw_remote_alarm_bit  = f1g1_ff[`PTOB_RAI];
  wire [2:0]  sw_link_status_value = f1g1_ff[`PTOB_LSS];
  wire [7:0]  sw_m2_value          = m12_ff[`PTOB_HI];
  wire [7:0]  sw_m1_value          = m12_ff[`PTOB_LO];
  wire [7:0]  sw_growth2_value     = z12_ff[`PTOB_HI];
  wire [7:0]  sw_growth1_value     = z12_ff[`PTOB_LO];
  wire [7:0]  sw_growth3_value     = z34_ff[`PTOB_LO];

  // Selected bytes from the source multiplexer.
  wire [7:0]  sel_f1;
  wire [7:0]  sel_g1;
  wire [7:0]  sel_m1;
  wire [7:0]  sel_m2;
  wire [7:0]  sel_z4;
  wire [7:0]  sel_z5;
  wire [7:0]  sel_z6;

  // Next values of the overhead outputs.
  reg         nxt_oh_valid;
  reg  [7:0]  nxt_f1_byte;
  reg  [7:0]  nxt_g1_byte;
  reg  [7:0]  nxt_m1_byte;
  reg  [7:0]  nxt_m2_byte;
  reg  [7:0]  nxt_z1_byte;
  reg  [7:0]  nxt_z2_byte;
  reg  [7:0]  nxt_z3_byte;
  reg  [7:0]  nxt_z4_byte;
  reg  [7:0]  nxt_z5_byte;
  reg  [7:0]  nxt_z6_byte;

  //////////////////////////////////////////////////////////////////////
  // Register port.
  //////////////////////////////////////////////////////////////////////

  // The upper byte of the control register reports the G1 byte last
  // handed to the frame generator, so software can see what went out.
  assign ctrl_rd = {o_g1_byte, `PTOB_RSVD2, ctrl_ff};

  // Decoder and read path.
  ptob_bus_slave u_bus (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_addr    (i_addr),
    .i_wr_en   (i_wr_en),
    .i_rd_en   (i_rd_en),
    .o_rd_data (o_rd_data),
    .i_f1g1    (f1g1_ff),
    .i_m12     (m12_ff),
    .i_z12     (z12_ff),
    .i_z34     (z34_ff),
    .i_z56     (z56_ff),
    .i_ctrl    (ctrl_rd),
    .o_wr_sel  (wr_sel)
  );

  // Next register values: a selected write loads the whole word (only
  // the control bits for control); otherwise the register keeps its value.
  always @* begin
    nxt_f1g1 = f1g1_ff;
    nxt_m12  = m12_ff;
    nxt_z12  = z12_ff;
    nxt_z34  = z34_ff;
    nxt_z56  = z56_ff;
    nxt_ctrl = ctrl_ff;
    // F1 above REI, alarm and link status.
    if (wr_sel[`PTOB_S_F1G1]) begin
      nxt_f1g1 = i_wr_data;
    end
    // M2 above M1.
    if (wr_sel[`PTOB_S_M12]) begin
      nxt_m12 = i_wr_data;
    end
    // Z2 above Z1.
    if (wr_sel[`PTOB_S_Z12]) begin
      nxt_z12 = i_wr_data;
    end
    // Z4 above Z3.
    if (wr_sel[`PTOB_S_Z34]) begin
      nxt_z34 = i_wr_data;
    end
    // Z6 above Z5.
    if (wr_sel[`PTOB_S_Z56]) begin
      nxt_z56 = i_wr_data;
    end
    // Only the control bits are writable; the status byte is not.
    if (wr_sel[`PTOB_S_CTRL]) begin
      nxt_ctrl = i_wr_data[`PTOB_C_BITS];
    end
  end

  // Storage flip-flops; all clear to zero on reset.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      f1g1_ff <= `PTOB_RST16;
      m12_ff  <= `PTOB_RST16;
      z12_ff  <= `PTOB_RST16;
      z34_ff  <= `PTOB_RST16;
      z56_ff  <= `PTOB_RST16;
      ctrl_ff <= `PTOB_RST6;
    end else begin
      f1g1_ff <= nxt_f1g1;
      m12_ff  <= nxt_m12;
      z12_ff  <= nxt_z12;
      z34_ff  <= nxt_z34;
      z56_ff  <= nxt_z56;
      ctrl_ff <= nxt_ctrl;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Overhead source selection.
  //////////////////////////////////////////////////////////////////////

  // Chooses between software values and the other byte sources.
  ptob_oh_mux u_mux (
    .i_f1g1     ({sw_f1_value, sw_remote_err_value, sw_remote_alarm_bit, sw_link_status_value}),
    .i_m12      ({sw_m2_value, sw_m1_value}),
    .i_z34      (z34_ff),
    .i_z56      (z56_ff),
    .i_ctrl     (ctrl_ff),
    .i_auto_rei (i_auto_rei),
    .i_trace_f1 (i_trace_f1),
    .i_hdlc_f1  (i_hdlc_f1),
    .i_hdlc_m1  (i_hdlc_m1),
    .i_hdlc_m2  (i_hdlc_m2),
    .o_f1       (sel_f1),
    .o_g1       (sel_g1),
    .o_m1       (sel_m1),
    .o_m2       (sel_m2),
    .o_z4       (sel_z4),
    .o_z5       (sel_z5),
    .o_z6       (sel_z6)
  );

  //////////////////////////////////////////////////////////////////////
  // Sampling at the insertion point.
  //////////////////////////////////////////////////////////////////////

  // The outputs hold between insertion pulses, so a software write in
  // the middle of a frame never splits a byte; it is sent from the next
  // pulse onward. A write in the pulse cycle itself lands after that
  // pulse has sampled the old contents.
  always @* begin
    nxt_oh_valid = i_oh_sample;
    nxt_f1_byte  = o_f1_byte;
    nxt_g1_byte  = o_g1_byte;
    nxt_m1_byte  = o_m1_byte;
    nxt_m2_byte  = o_m2_byte;
    nxt_z1_byte  = o_z1_byte;
    nxt_z2_byte  = o_z2_byte;
    nxt_z3_byte  = o_z3_byte;
    nxt_z4_byte  = o_z4_byte;
    nxt_z5_byte  = o_z5_byte;
    nxt_z6_byte  = o_z6_byte;
    if (i_oh_sample) begin
      nxt_f1_byte = sel_f1;
      nxt_g1_byte = sel_g1;
      nxt_m1_byte = sel_m1;
      nxt_m2_byte = sel_m2;
      nxt_z1_byte = sw_growth1_value;
      nxt_z2_byte = sw_growth2_value;
      nxt_z3_byte = sw_growth3_value;
      nxt_z4_byte = sel_z4;
      nxt_z5_byte = sel_z5;
      nxt_z6_byte = sel_z6;
    end
  end

  // Output flip-flops; zero bytes until the first insertion pulse.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_oh_valid <= `PTOB_RST1;
      o_f1_byte  <= `PTOB_RST8;
      o_g1_byte  <= `PTOB_RST8;
      o_m1_byte  <= `PTOB_RST8;
      o_m2_byte  <= `PTOB_RST8;
      o_z1_byte  <= `PTOB_RST8;
      o_z2_byte  <= `PTOB_RST8;
      o_z3_byte  <= `PTOB_RST8;
      o_z4_byte  <= `PTOB_RST8;
      o_z5_byte  <= `PTOB_RST8;
      o_z6_byte  <= `PTOB_RST8;
    end else begin
      o_oh_valid <= nxt_oh_valid;
      o_f1_byte  <= nxt_f1_byte;
      o_g1_byte  <= nxt_g1_byte;
      o_m1_byte  <= nxt_m1_byte;
      o_m2_byte  <= nxt_m2_byte;
      o_z1_byte  <= nxt_z1_byte;
      o_z2_byte  <= nxt_z2_byte;
      o_z3_byte  <= nxt_z3_byte;
      o_z4_byte  <= nxt_z4_byte;
      o_z5_byte  <= nxt_z5_byte;
      o_z6_byte  <= nxt_z6_byte;
    end
  end

endmodule // ptob_regs

/* File: tb/ptob_regs_asserts.sv */
// Purpose: Port-level checks for the transmit overhead byte bank.
// Assumes: One clock; asynchronous active-high reset.
// Notes:   Shadow copies built from bus writes give the expected bytes.
`timescale 1ns/10ps
`include "ptob_defs.vh"

module ptob_regs_chk (
  // Clock and reset.
  input wire        i_sys_clk,
  input wire        i_rst,
  // Register port.
  input wire [7:0]  i_addr,
  input wire [15:0] i_wr_data,
  input wire        i_wr_en,
  input wire        i_rd_en,
  input wire [15:0] o_rd_data,
  // Overhead side.
  input wire        i_oh_sample,
  input wire [3:0]  i_auto_rei,
  input wire [7:0]  i_trace_f1,
  input wire [7:0]  i_hdlc_f1,
  input wire [7:0]  i_hdlc_m1,
  input wire [7:0]  i_hdlc_m2,
  input wire        o_oh_valid,
  input wire [7:0]  o_f1_byte,
  input wire [7:0]  o_g1_byte,
  input wire [7:0]  o_m1_byte,
  input wire [7:0]  o_m2_byte,
  input wire [7:0]  o_z1_byte,
  input wire [7:0]  o_z2_byte,
  input wire [7:0]  o_z3_byte,
  input wire [7:0]  o_z4_byte,
  input wire [7:0]  o_z5_byte,
  input wire [7:0]  o_z6_byte
);
  ////////////////////////////////////////
  reg  [15:0] sh_ff [0:7];  // Written values; slot 7 is control.
  integer     k;            // Reset loop index.
  wire [15:0] ctl  = sh_ff[7];
  wire [2:0]  ix   = i_addr[3:1];
  wire        map  = i_addr[7:4] == 4'h5 && !i_addr[0] && ix >= 3'h2 && ix <= 3'h6;
  wire [1:0]  fsel = ctl[2:1];
  wire [7:0]  e_f1 = fsel == `PTOB_F1_REG ? sh_ff[2][15:8] : fsel == `PTOB_F1_HDLC ? i_hdlc_f1 :
                     fsel == `PTOB_F1_TRACE ? i_trace_f1 : 8'h00;
  wire [7:0]  e_g1 = {ctl[0] ? sh_ff[2][7:4] : i_auto_rei, sh_ff[2][3:0]};
  wire [15:0] e_m  = {ctl[4] ? sh_ff[3][15:8] : i_hdlc_m2, ctl[3] ? sh_ff[3][7:0] : i_hdlc_m1};
  wire [23:0] e_lo = {sh_ff[4], sh_ff[5][7:0]};
  wire [23:0] e_hi = ctl[5] ? 24'h000000 : {sh_ff[5][15:8], sh_ff[6]};
  wire [15:0] e_rd = map ? sh_ff[ix] : 16'h0000;
  wire [79:0] oh   = {o_f1_byte, o_g1_byte, o_m1_byte, o_m2_byte, o_z1_byte, o_z2_byte, o_z3_byte,
                      o_z4_byte, o_z5_byte, o_z6_byte};

  // Shadow follows every accepted write; control keeps the whole word, low six bits used.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (k = 0; k < 8; k = k + 1)
        sh_ff[k] <= 16'h0000;
    end else if (i_wr_en && (map || i_addr == `PTOB_ADR_CTRL)) begin
      sh_ff[ix] <= i_wr_data;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_valid; i_oh_sample |=> o_oh_valid; endproperty
  property p_quiet; !i_oh_sample |=> !o_oh_valid && $stable(oh); endproperty
  property p_f1; i_oh_sample |=> o_f1_byte == $past(e_f1); endproperty
  property p_g1; i_oh_sample |=> o_g1_byte == $past(e_g1); endproperty
  property p_m; i_oh_sample |=> {o_m2_byte, o_m1_byte} == $past(e_m); endproperty
  property p_zlo; i_oh_sample |=> {o_z2_byte, o_z1_byte, o_z3_byte} == $past(e_lo); endproperty
  property p_zhi; i_oh_sample |=> {o_z4_byte, o_z6_byte, o_z5_byte} == $past(e_hi); endproperty
  property p_rd; i_rd_en && i_addr != `PTOB_ADR_CTRL |=> o_rd_data == $past(e_rd); endproperty
  property p_rd_idle; !i_rd_en |=> o_rd_data == 16'h0000; endproperty
  a_valid: assert property (p_valid) else $error("valid missing after sample");
  a_quiet: assert property (p_quiet) else $error("bytes moved without sample");
  a_f1: assert property (p_f1) else $error("F1 byte wrong");
  a_g1: assert property (p_g1) else $error("G1 byte wrong");
  a_m: assert property (p_m) else $error("M bytes wrong");
  a_zlo: assert property (p_zlo) else $error("Z1 Z2 Z3 wrong");
  a_zhi: assert property (p_zhi) else $error("Z4 Z5 Z6 wrong");
  a_rd: assert property (p_rd) else $error("read data wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  c_e3: cover property (i_oh_sample && ctl[5]);
  c_wr_rd: cover property (i_wr_en && map ##1 i_rd_en);
  c_f1_reg: cover property (i_oh_sample && fsel == `PTOB_F1_REG);
endmodule // ptob_regs_chk

bind ptob_regs ptob_regs_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_oh_sample(i_oh_sample), .i_auto_rei(i_auto_rei),
  .i_trace_f1(i_trace_f1), .i_hdlc_f1(i_hdlc_f1), .i_hdlc_m1(i_hdlc_m1), .i_hdlc_m2(i_hdlc_m2),
  .o_oh_valid(o_oh_valid), .o_f1_byte(o_f1_byte), .o_g1_byte(o_g1_byte), .o_m1_byte(o_m1_byte),
  .o_m2_byte(o_m2_byte), .o_z1_byte(o_z1_byte), .o_z2_byte(o_z2_byte), .o_z3_byte(o_z3_byte),
  .o_z4_byte(o_z4_byte), .o_z5_byte(o_z5_byte), .o_z6_byte(o_z6_byte));

/* File: tb/ptob_regs_tb.sv */
// Purpose: Self-checking bench for the transmit overhead byte bank.
// Assumes: Bench drives every input; results are queued and matched.
// Notes:   Random values come from an xorshift started at 8311.
`timescale 1ns/10ps
`include "ptob_defs.vh"

module ptob_regs_tb;
  reg         i_sys_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg  [7:0]  i_addr = 8'h00;
  reg  [15:0] i_wr_data = 16'h0000;
  reg         i_wr_en = 1'b0, i_rd_en = 1'b0, i_oh_sample = 1'b0;
  reg  [3:0]  i_auto_rei = 4'h0;
  reg  [7:0]  i_trace_f1 = 8'h00, i_hdlc_f1 = 8'h00, i_hdlc_m1 = 8'h00, i_hdlc_m2 = 8'h00;
  wire [15:0] o_rd_data;
  wire        o_oh_valid;
  wire [7:0]  o_f1_byte, o_g1_byte, o_m1_byte, o_m2_byte, o_z1_byte;
  wire [7:0]  o_z2_byte, o_z3_byte, o_z4_byte, o_z5_byte, o_z6_byte;
  reg  [15:0] m [0:7];         // Register model; slot 7 is control.
  reg  [7:0]  g1_now;          // G1 byte the outputs should hold now.
  reg         rd_pend = 1'b0;  // A read result is due this cycle.
  reg  [31:0] rs = 32'h00002077, v;  // Xorshift state; starts at 8311.
  reg  [79:0] rd_q [$], oh_q [$];
  integer     mismatches = 0, tests_run = 0, cycles = 0, i;

  always #10 i_sys_clk = ~i_sys_clk;

  ptob_regs uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_oh_sample(i_oh_sample), .i_auto_rei(i_auto_rei),
    .i_trace_f1(i_trace_f1), .i_hdlc_f1(i_hdlc_f1), .i_hdlc_m1(i_hdlc_m1), .i_hdlc_m2(i_hdlc_m2),
    .o_oh_valid(o_oh_valid), .o_f1_byte(o_f1_byte), .o_g1_byte(o_g1_byte), .o_m1_byte(o_m1_byte),
    .o_m2_byte(o_m2_byte), .o_z1_byte(o_z1_byte), .o_z2_byte(o_z2_byte), .o_z3_byte(o_z3_byte),
    .o_z4_byte(o_z4_byte), .o_z5_byte(o_z5_byte), .o_z6_byte(o_z6_byte));

  ////////////////////////////////////////
  function [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    rnd = rs;
  endfunction

  // Data register addresses answer; every other address but control reads zero.
  function mp(input [7:0] a);
    mp = a[7:4] == 4'h5 && !a[0] && a[3:1] >= 3'h2 && a[3:1] <= 3'h6;
  endfunction

  task chk(input string nm, input [79:0] e, input [79:0] g);
    tests_run = tests_run + 1;
    if (e !== g) begin
      mismatches = mismatches + 1;
      $display("unexpected %0s exp %h got %h", nm, e, g);
    end
  endtask

  task report_and_stop;
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One bus cycle with optional sample; expected results are queued.
  task cyc(input w, input r, input s, input [7:0] a, input [15:0] d);
    reg [63:0] x;
    reg [15:0] c;
    reg [7:0]  f1, g1;
    x = {rnd(), rnd()};
    c = m[7];
    @(posedge i_sys_clk);
    i_wr_en <= w;
    i_rd_en <= r;
    i_oh_sample <= s;
    i_addr <= a;
    i_wr_data <= d;
    {i_auto_rei, i_trace_f1, i_hdlc_f1, i_hdlc_m1, i_hdlc_m2} <= x[35:0];
    f1 = c[2:1] == `PTOB_F1_REG ? m[2][15:8] : c[2:1] == `PTOB_F1_HDLC ? x[23:16] :
         c[2:1] == `PTOB_F1_TRACE ? x[31:24] : 8'h00;
    g1 = {c[0] ? m[2][7:4] : x[35:32], m[2][3:0]};
    if (r)
      rd_q.push_back(a == `PTOB_ADR_CTRL ? {g1_now, c[7:0]} : mp(a) ? m[a[3:1]] : 16'h0000);
    if (s) begin
      oh_q.push_back({f1, g1, c[3] ? m[3][7:0] : x[15:8], c[4] ? m[3][15:8] : x[7:0], m[4][7:0],
                      m[4][15:8], m[5][7:0], c[5] ? 24'h000000 : {m[5][15:8], m[6][7:0], m[6][15:8]}});
      g1_now = g1;
    end
    if (w && a == `PTOB_ADR_CTRL)
      m[7] = d & 16'h003F;
    else if (w && mp(a))
      m[a[3:1]] = d;
  endtask

  // Reset held five cycles; the model clears with it.
  task rst_seq;
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
      m[i] = 16'h0000;
    g1_now = 8'h00;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
  endtask

  // Reads over the bank, its neighbours and the control place.
  task read_all;
    for (i = 8'h50; i < 8'h62; i = i + 2)
      cyc(0, 1, 0, i[7:0], 16'h0000);
  endtask

  ////////////////////////////////////////
  // Cycle count guards against a hang; read strobe is remembered.
  always @(posedge i_sys_clk) begin
    rd_pend <= i_rd_en;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end

  // Results are matched against the oldest note when they appear.
  always @(negedge i_sys_clk) begin
    if (!i_rst && rd_pend)
      chk("read data", rd_q.size() ? rd_q.pop_front() : 'x, o_rd_data);
    if (!i_rst && o_oh_valid)
      chk("overhead", oh_q.size() ? oh_q.pop_front() : 'x, {o_f1_byte, o_g1_byte, o_m1_byte,
          o_m2_byte, o_z1_byte, o_z2_byte, o_z3_byte, o_z4_byte, o_z5_byte, o_z6_byte});
  end

  initial begin
    rst_seq;
    read_all;
    for (i = 8'h50; i < 8'h62; i = i + 2) begin
      v = rnd();
      cyc(1, 0, 0, i[7:0], v[15:0]);
      cyc(0, 1, 0, i[7:0], 16'h0000);
    end
    for (i = 0; i < 64; i = i + 1) begin
      v = rnd();
      cyc(1, 0, 0, `PTOB_ADR_CTRL, {v[31:22], i[5:0]});
      cyc(1, 0, 1, 8'h54 + 8'h02 * (v[2:0] % 3'h5), v[31:16]);
      cyc(0, 1, 1, `PTOB_ADR_CTRL, 16'h0000);
      cyc(0, 1, 1, 8'h54 + 8'h02 * (v[5:3] % 3'h5), 16'h0000);
    end
    cyc(0, 0, 0, 8'h00, 16'h0000);
    cyc(0, 0, 0, 8'h00, 16'h0000);
    rst_seq;
    read_all;
    cyc(0, 0, 1, 8'h00, 16'h0000);
    repeat (3) cyc(0, 0, 0, 8'h00, 16'h0000);
    chk("pending", 80'h0, rd_q.size() + oh_q.size());
    report_and_stop;
  end
endmodule // ptob_regs_tb
